// [core/hbi_pkg.sv]
`default_nettype none
package hbi_pkg;
  // ---------------------------------------------------------------
  // register pick codes
  // ---------------------------------------------------------------
  localparam logic [1:0] PICK_PORT_A = 2'h0;
  localparam logic [1:0] PICK_CTRL_A = 2'h1;
  localparam logic [1:0] PICK_PORT_B = 2'h2;
  localparam logic [1:0] PICK_CTRL_B = 2'h3;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CR_IN_EN      = 0;  // enable for the input-only control line
  localparam int CR_IN_RISE    = 1;  // 1: rising edge is active
  localparam int CR_DATA_SEL   = 2;  // 1: data register, 0: direction register
  localparam int CR_IO_EN      = 3;  // enable for the two-way control line
  localparam int CR_IO_RISE    = 4;
  localparam int CR_IO_OUTMODE = 5;  // 1: two-way line is an output, no flag
  localparam int CR_FLAG_IO    = 6;
  localparam int CR_FLAG_IN    = 7;
  localparam int CR_W          = 6;  // host-writable width

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]      BYTE_RST = 8'h00;
  localparam logic [CR_W-1:0] CR_RST   = 6'h00;

  // flag channel numbering
  localparam int FL_A_IN = 0;
  localparam int FL_A_IO = 1;
  localparam int FL_B_IN = 2;
  localparam int FL_B_IO = 3;
  localparam int FL_N    = 4;
endpackage
`default_nettype wire

// [core/flag_if.sv]
`default_nettype none
interface flag_if;
  logic sample;    // one-cycle pulse at the strobe's trailing edge
  logic deselect;  // trailing edge seen while not selected
  logic clear;     // read of the owning port's data register
  logic line;      // control line level
  logic rise_sel;  // 1: rising edge is active
  logic is_input;  // line may set its flag
  logic flag;
  modport ctrl (output sample, output deselect, output clear, output line,
                output rise_sel, output is_input, input flag);
  modport unit (input sample, input deselect, input clear, input line,
                input rise_sel, input is_input, output flag);
endinterface
`default_nettype wire

// [core/flag_unit.sv]
`default_nettype none
module flag_unit (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // link to the bus logic
  flag_if.unit      lnk
);
  typedef struct packed {
    logic line_prev;
    logic cond;
    logic armed;
    logic flag;
  } unit_t;

  unit_t s_r;
  unit_t s_nxt;
  logic  active;
  logic  set_ev;

  always_comb begin
    active = lnk.rise_sel ? lnk.line : ~lnk.line;
    // edge only counts when conditioned and re-armed after a clear
    set_ev = lnk.is_input && (lnk.line != s_r.line_prev) && active
             && s_r.cond && s_r.armed;  // RULE14
    s_nxt = s_r;
    s_nxt.line_prev = lnk.line;
    // strobe sees the line at its inactive level: detector conditioned
    if (lnk.sample && !active) begin
      s_nxt.cond = 1'b1;  // RULE13
    end
    if (lnk.deselect) begin
      s_nxt.armed = 1'b1;  // RULE12
    end
    if (lnk.clear) begin
      s_nxt.flag  = 1'b0;  // RULE11
      s_nxt.armed = 1'b0;  // RULE12
    end
    // a set in the clearing cycle wins, so the event is not lost
    if (set_ev) begin
      s_nxt.flag = 1'b1;  // RULE14
      s_nxt.cond = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;  // RULE5
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.flag = s_r.flag;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_flag_clears: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
    (lnk.clear && !set_ev) |=> !s_r.flag) else $error("flag not cleared on read");
  a_rearm_first: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
    $rose(s_r.flag) |-> $past(s_r.armed)) else $error("flag set before re-arm");
  a_cond_first: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
    $rose(s_r.flag) |-> $past(s_r.cond) && $past(lnk.is_input))
    else $error("flag set without conditioning");
  a_edge_sets: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    set_ev |=> s_r.flag ##0 !s_r.cond) else $error("active edge lost");
endmodule
`default_nettype wire

// [core/host_bus_irq.sv]
// How it works
// [RULE1] data bus drivers stay off except during a host read
// [RULE2] enable strobe alone times the bus; other pins sampled at its edges
// [RULE3] selected write with direction low stores bus data at the strobe
// [RULE4] selected read drives the addressed register while the strobe is high
// [RULE5] active-low reset zeroes every internal register bit
// [RULE6] selected only with both high selects high and the low select low
// [RULE7] host keeps selects and register picks stable across each strobe
// [RULE8] register chosen by the two pick inputs plus control register bits
// [RULE9] both interrupt requests are open drain, low-active, no pull-up
// [RULE10] each request pulled low by two flags, four enables gate them
// [RULE11] reading a port's data register clears that port's flags
// [RULE12] a cleared flag re-arms only after a deselected strobe
// [RULE13] a strobe between inactive and active edge conditions the detector
// [RULE14] conditioned, armed flag sets on the next programmed active edge
// [RULE15] host should qualify selection with its valid-cycle signal
// [RULE16] picks: 00 port A, 01 control A, 10 port B, 11 control B
// [RULE17] control bit 2 picks data register (1) or direction register (0)
// [RULE18] control bits 7 and 6 are read-only flags, never written by host
// [RULE19] request low while any flag is set with its enable bit one
`default_nettype none
module host_bus_irq (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // host bus
  input  wire logic       e_strobe,
  input  wire logic       rw,
  input  wire logic       select_high_first,
  input  wire logic       select_high_second,
  input  wire logic       select_low_n,
  input  wire logic       reg_pick_lsb,
  input  wire logic       reg_pick_msb,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe,
  // interrupt requests, open drain
  output logic            port_a_irq_n_out,
  output logic            port_a_irq_n_oe,
  output logic            port_b_irq_n_out,
  output logic            port_b_irq_n_oe,
  // peripheral port A
  input  wire logic [7:0] port_a_in,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_a_oe,
  // peripheral port B
  input  wire logic [7:0] port_b_in,
  output logic      [7:0] port_b_out,
  output logic      [7:0] port_b_oe,
  // control lines, used here as interrupt inputs
  input  wire logic       port_a_ctrl_in,
  input  wire logic       port_a_ctrl_io,
  input  wire logic       port_b_ctrl_in,
  input  wire logic       port_b_ctrl_io
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                      e_prev;
    logic [7:0]                rd_data;
    logic                      rd_oe;
    logic                      irq_a_oe;
    logic                      irq_b_oe;
    logic                      irq_lvl;
    logic [7:0]                out_a;
    logic [7:0]                ddr_a;
    logic [7:0]                out_b;
    logic [7:0]                ddr_b;
    logic [hbi_pkg::CR_W-1:0]  port_a_control;
    logic [hbi_pkg::CR_W-1:0]  port_b_control;
  } state_t;

  state_t     s_r;
  state_t     s_nxt;
  logic       sel;
  logic [1:0] pick;
  logic       e_fall;
  logic       wr_take;
  logic       rd_take;
  logic       clr_a;
  logic       clr_b;
  logic [7:0] rd_val;
  logic [7:0] port_b_view;
  logic       req_a;
  logic       req_b;
  logic [hbi_pkg::FL_N-1:0] flags;
  logic [hbi_pkg::FL_N-1:0] lines;
  logic [hbi_pkg::FL_N-1:0] rises;
  logic [hbi_pkg::FL_N-1:0] ins;
  logic [hbi_pkg::FL_N-1:0] clrs;

  // ---------------------------------------------------------------
  // selection and strobe edges
  // ---------------------------------------------------------------
  // strobe input is synchronous, so one register gives its edges;
  // selects and picks are trusted stable for the whole strobe;
  // a deselected trailing edge still matters: it re-arms cleared flags
  always_comb begin
    sel     = select_high_first && select_high_second && !select_low_n;  // RULE6
    pick    = {reg_pick_msb, reg_pick_lsb};
    e_fall  = s_r.e_prev && !e_strobe;                     // RULE2
    wr_take = e_fall && sel && !rw;                        // RULE3 RULE7
    rd_take = e_fall && sel && rw;                         // RULE7
    clr_a   = rd_take && (pick == hbi_pkg::PICK_PORT_A)
              && s_r.port_a_control[hbi_pkg::CR_DATA_SEL];            // RULE11
    clr_b   = rd_take && (pick == hbi_pkg::PICK_PORT_B)
              && s_r.port_b_control[hbi_pkg::CR_DATA_SEL];            // RULE11
  end

  // ---------------------------------------------------------------
  // flag channels
  // ---------------------------------------------------------------
  always_comb begin
    lines = {port_b_ctrl_io, port_b_ctrl_in, port_a_ctrl_io, port_a_ctrl_in};
    rises = {s_r.port_b_control[hbi_pkg::CR_IO_RISE], s_r.port_b_control[hbi_pkg::CR_IN_RISE],
             s_r.port_a_control[hbi_pkg::CR_IO_RISE], s_r.port_a_control[hbi_pkg::CR_IN_RISE]};
    // two-way lines raise flags only while programmed as inputs
    ins   = {!s_r.port_b_control[hbi_pkg::CR_IO_OUTMODE], 1'b1,
             !s_r.port_a_control[hbi_pkg::CR_IO_OUTMODE], 1'b1};
    clrs  = {clr_b, clr_b, clr_a, clr_a};
  end

  flag_if fl [hbi_pkg::FL_N] ();

  genvar gi;
  generate
    for (gi = 0; gi < hbi_pkg::FL_N; gi++) begin : g_flag
      assign fl[gi].sample   = e_fall;                     // RULE13
      assign fl[gi].deselect = e_fall && !sel;             // RULE12
      assign fl[gi].clear    = clrs[gi];
      assign fl[gi].line     = lines[gi];
      assign fl[gi].rise_sel = rises[gi];
      assign fl[gi].is_input = ins[gi];
      assign flags[gi]       = fl[gi].flag;
      flag_unit u_flag (
        .clk   (clk),
        .rst_b (rst_b),
        .lnk   (fl[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    // port B reads its own latch on output bits, the pin on inputs
    port_b_view = (s_r.out_b & s_r.ddr_b) | (port_b_in & ~s_r.ddr_b);
    unique case (pick)  // RULE8 RULE16
      hbi_pkg::PICK_PORT_A: begin
        rd_val = s_r.port_a_control[hbi_pkg::CR_DATA_SEL] ? port_a_in : s_r.ddr_a;  // RULE17
      end
      hbi_pkg::PICK_CTRL_A: begin
        rd_val = {flags[hbi_pkg::FL_A_IN], flags[hbi_pkg::FL_A_IO], s_r.port_a_control};
      end
      hbi_pkg::PICK_PORT_B: begin
        rd_val = s_r.port_b_control[hbi_pkg::CR_DATA_SEL] ? port_b_view : s_r.ddr_b;  // RULE17
      end
      hbi_pkg::PICK_CTRL_B: begin
        rd_val = {flags[hbi_pkg::FL_B_IN], flags[hbi_pkg::FL_B_IO], s_r.port_b_control};
      end
    endcase
  end

  // ---------------------------------------------------------------
  // interrupt requests
  // ---------------------------------------------------------------
  always_comb begin
    // registered below, so a request trails its flag by one cycle
    req_a = (flags[hbi_pkg::FL_A_IN] && s_r.port_a_control[hbi_pkg::CR_IN_EN])
         || (flags[hbi_pkg::FL_A_IO] && s_r.port_a_control[hbi_pkg::CR_IO_EN]);  // RULE10 RULE19
    req_b = (flags[hbi_pkg::FL_B_IN] && s_r.port_b_control[hbi_pkg::CR_IN_EN])
         || (flags[hbi_pkg::FL_B_IO] && s_r.port_b_control[hbi_pkg::CR_IO_EN]);  // RULE10 RULE19
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.e_prev   = e_strobe;
    s_nxt.irq_a_oe = req_a;
    s_nxt.irq_b_oe = req_b;
    s_nxt.irq_lvl  = 1'b0;  // RULE9
    // drive only during a selected read strobe, off one cycle after it;
    // data falls back to zero with the enable so no stale byte lingers
    s_nxt.rd_oe    = e_strobe && sel && rw;       // RULE1 RULE4
    s_nxt.rd_data  = (e_strobe && sel && rw) ? rd_val : hbi_pkg::BYTE_RST;  // RULE4
    if (wr_take) begin
      unique case (pick)  // RULE8 RULE16
        hbi_pkg::PICK_PORT_A: begin
          if (s_r.port_a_control[hbi_pkg::CR_DATA_SEL]) begin  // RULE17
            s_nxt.out_a = host_data_in;           // RULE3
          end else begin
            s_nxt.ddr_a = host_data_in;
          end
        end
        hbi_pkg::PICK_CTRL_A: begin
          // flag bits are not stored from the bus
          s_nxt.port_a_control = host_data_in[hbi_pkg::CR_W-1:0];  // RULE18
        end
        hbi_pkg::PICK_PORT_B: begin
          if (s_r.port_b_control[hbi_pkg::CR_DATA_SEL]) begin  // RULE17
            s_nxt.out_b = host_data_in;           // RULE3
          end else begin
            s_nxt.ddr_b = host_data_in;
          end
        end
        hbi_pkg::PICK_CTRL_B: begin
          s_nxt.port_b_control = host_data_in[hbi_pkg::CR_W-1:0];  // RULE18
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;  // RULE5
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from state flops
  // ---------------------------------------------------------------
  assign host_data_out    = s_r.rd_data;
  assign host_data_oe     = s_r.rd_oe;
  assign port_a_irq_n_out = s_r.irq_lvl;
  assign port_a_irq_n_oe  = s_r.irq_a_oe;
  assign port_b_irq_n_out = s_r.irq_lvl;
  assign port_b_irq_n_oe  = s_r.irq_b_oe;
  assign port_a_out       = s_r.out_a;
  assign port_a_oe        = s_r.ddr_a;
  assign port_b_out       = s_r.out_b;
  assign port_b_oe        = s_r.ddr_b;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // bus drive
  a_bus_float: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    host_data_oe |-> $past(e_strobe) && $past(sel) && $past(rw))
    else $error("data bus driven outside a read");
  a_desel_quiet: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    (e_strobe && !sel) |=> !host_data_oe)
    else $error("data bus driven while deselected");
  a_read_drive: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    (e_strobe && sel && rw) |=> host_data_oe && (host_data_out == $past(rd_val)))
    else $error("read data not driven");

  // register writes; they move only at a trailing strobe edge
  a_strobe_only: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    !e_fall |=> $stable(s_r.port_a_control) && $stable(s_r.port_b_control) && $stable(s_r.ddr_a)
                && $stable(s_r.out_a) && $stable(s_r.ddr_b) && $stable(s_r.out_b))
    else $error("register changed outside a strobe edge");
  a_write_ctrl: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
    (wr_take && pick == hbi_pkg::PICK_CTRL_A)
    |=> s_r.port_a_control == $past(host_data_in[hbi_pkg::CR_W-1:0]))
    else $error("control write not taken");
  a_port_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    (wr_take && pick == hbi_pkg::PICK_PORT_A && s_r.port_a_control[hbi_pkg::CR_DATA_SEL])
    |=> s_r.out_a == $past(host_data_in) && $stable(s_r.ddr_a))
    else $error("port A write went astray");
  a_no_sel_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    (e_fall && !sel) |=> $stable(s_r.ddr_a) && $stable(s_r.out_b) && $stable(s_r.port_b_control))
    else $error("write while deselected");
  a_ddr_steer: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
    (wr_take && pick == hbi_pkg::PICK_PORT_B && !s_r.port_b_control[hbi_pkg::CR_DATA_SEL])
    |=> s_r.ddr_b == $past(host_data_in) && $stable(s_r.out_b))
    else $error("direction register not steered");

  // interrupt requests
  a_irq_cause: assert property (@(posedge clk) disable iff (!rst_b) // RULE19
    port_a_irq_n_oe |-> $past(req_a) ##0 !port_a_irq_n_out)
    else $error("request A without enabled flag");
  a_irq_release: assert property (@(posedge clk) disable iff (!rst_b) // RULE19
    !req_a |=> !port_a_irq_n_oe) else $error("request A not released");
  a_irq_follow: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
    req_b |=> port_b_irq_n_oe) else $error("request B missed");
  a_b_release: assert property (@(posedge clk) disable iff (!rst_b) // RULE19
    !req_b |=> !port_b_irq_n_oe) else $error("request B not released");

  // flags; a fresh edge in the clearing cycle may set the flag again
  a_flag_ro: assert property (@(posedge clk) disable iff (!rst_b) // RULE18
    (wr_take && pick == hbi_pkg::PICK_CTRL_B && !flags[hbi_pkg::FL_B_IN]
     && lines[hbi_pkg::FL_B_IN] == $past(lines[hbi_pkg::FL_B_IN]))
    |=> !flags[hbi_pkg::FL_B_IN]) else $error("flag written from bus");
  a_read_clear: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
    clr_a |=> !flags[hbi_pkg::FL_A_IN]
              || ($past(lines[hbi_pkg::FL_A_IN]) != $past(lines[hbi_pkg::FL_A_IN], 2)))
    else $error("port A read did not clear");
  a_clear_port_b: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
    clr_b |=> !flags[hbi_pkg::FL_B_IN]
              || ($past(lines[hbi_pkg::FL_B_IN]) != $past(lines[hbi_pkg::FL_B_IN], 2)))
    else $error("port B read did not clear");
endmodule
`default_nettype wire

// [tb/host_bfm.sv]
`default_nettype none
module host_bfm (
  // clock
  input  wire logic       clk,
  // bus towards the device
  output var logic        e_strobe,
  output var logic        rw,
  output var logic [2:0]  sel,
  output var logic [1:0]  pick,
  output logic     [7:0]  bus,
  // device answer
  input  wire logic [7:0] dout,
  input  wire logic       doe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drv;
  logic [7:0] last = 8'h00;
  logic       drv_en;

  // undriven bus toggles every cycle so a stale value never reads as valid
  assign bus = doe ? dout : (drv_en ? drv : ~last);
  always @(posedge clk) last <= bus;

  initial begin
    e_strobe = 1'b0;
    rw = 1'b1;
    sel = 3'h0;
    pick = 2'h0;
    drv = 8'h00;
    drv_en = 1'b0;
  end

  // ---------------------------------------------------------------
  // one strobe, two cycles high, selects held across it
  // ---------------------------------------------------------------
  task automatic xfer(input logic r, input logic [2:0] s, input logic [1:0] p,
                      input logic [7:0] w, output logic [7:0] q, output logic om,
                      output logic oe2);
    @(posedge clk);
    #5;
    e_strobe = 1'b1;
    rw = r;
    sel = s;
    pick = p;
    drv = w;
    drv_en = !r;
    @(posedge clk);
    @(negedge clk);
    q = dout;
    om = doe;
    @(posedge clk);
    #5 e_strobe = 1'b0;
    @(posedge clk);
    #5;
    sel = 3'h0;
    rw = 1'b1;
    drv_en = 1'b0;
    @(negedge clk);
    oe2 = doe;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_b, e_strobe, rw, doe, a_out, a_oe, b_out, b_oe;
  logic [2:0] sel;
  logic [1:0] pick;
  logic [7:0] bus, dout, pa_in, pb_in, pa_out, pa_oe, pb_out, pb_oe;
  logic [3:0] lines, fl;
  logic [5:0] port_a_control, port_b_control;
  logic [7:0] ddra, outa, ddrb, outb;
  int         n_fail, check_count, cyc;

  host_bfm host (.clk(clk), .e_strobe(e_strobe), .rw(rw), .sel(sel), .pick(pick),
                 .bus(bus), .dout(dout), .doe(doe));

  host_bus_irq dut (.clk(clk), .rst_b(rst_b), .e_strobe(e_strobe), .rw(rw),
    .select_high_first(sel[2]), .select_high_second(sel[1]), .select_low_n(sel[0]),
    .reg_pick_lsb(pick[0]), .reg_pick_msb(pick[1]), .host_data_in(bus),
    .host_data_out(dout), .host_data_oe(doe),
    .port_a_irq_n_out(a_out), .port_a_irq_n_oe(a_oe),
    .port_b_irq_n_out(b_out), .port_b_irq_n_oe(b_oe),
    .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe(pa_oe),
    .port_b_in(pb_in), .port_b_out(pb_out), .port_b_oe(pb_oe),
    .port_a_ctrl_in(lines[0]), .port_a_ctrl_io(lines[1]),
    .port_b_ctrl_in(lines[2]), .port_b_ctrl_io(lines[3]));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // expectation model and checking
  // ---------------------------------------------------------------
  function automatic logic [7:0] exp_rd(input logic [1:0] p);
    case (p)
      hbi_pkg::PICK_PORT_A: return port_a_control[2] ? pa_in : ddra;
      hbi_pkg::PICK_CTRL_A: return {fl[0], fl[1], port_a_control};
      hbi_pkg::PICK_PORT_B: return port_b_control[2] ? ((outb & ddrb) | (pb_in & ~ddrb)) : ddrb;
      default: return {fl[2], fl[3], port_b_control};
    endcase
  endfunction

  task automatic zero();
    port_a_control = 6'h00;
    port_b_control = 6'h00;
    ddra = 8'h00;
    outa = 8'h00;
    ddrb = 8'h00;
    outb = 8'h00;
    fl = 4'h0;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic op(input logic r, input logic [1:0] p, input logic [7:0] w);
    logic [7:0] q, e;
    logic       om, oe2;
    e = exp_rd(p);
    host.xfer(r, 3'b110, p, w, q, om, oe2);
    chk({7'h00, oe2}, 8'h00, "bus released after strobe");
    chk({7'h00, om}, {7'h00, r}, "bus drive during strobe");
    if (r) begin
      chk(q, e, "read data");
      if (!p[0] && (p[1] ? port_b_control[2] : port_a_control[2]))
        fl[{p[1], 1'b0} +: 2] = 2'h0;
    end else begin
      case (p)
        2'h0: if (port_a_control[2]) outa = w; else ddra = w;
        2'h1: port_a_control = w[5:0];
        2'h2: if (port_b_control[2]) outb = w; else ddrb = w;
        default: port_b_control = w[5:0];
      endcase
    end
  endtask

  task automatic desel(input logic r, input logic [1:0] p, input logic [7:0] w);
    logic [2:0] s;
    logic [7:0] q;
    logic       om, oe2;
    s = 3'($urandom_range(0, 6));
    if (s == 3'h6) s = 3'h7;
    host.xfer(r, s, p, w, q, om, oe2);
    chk({7'h00, om}, 8'h00, "deselected drive");
  endtask

  task automatic chan(input logic [1:0] k, input logic rise, input logic en);
    logic [5:0] cfg;
    logic [1:0] pc, pd;
    cfg = k[0] ? {1'b0, rise, en, 3'b100} : {4'b0001, rise, en};
    pc = {k[1], 1'b1};
    pd = {k[1], 1'b0};
    op(1'b0, pc, {2'b00, cfg});
    op(1'b1, pd, 8'h00);
    desel(1'b0, pc, 8'hff);
    @(posedge clk) #5 lines[k] = !rise;
    desel(1'b1, pd, 8'h00);
    op(1'b1, pc, 8'h00);
    @(posedge clk) #5 lines[k] = rise;
    repeat (3) @(posedge clk);
    #5 fl[k] = 1'b1;
    chk({7'h00, k[1] ? b_oe : a_oe}, {7'h00, en}, "request level");
    chk({7'h00, k[1] ? b_out : a_out}, 8'h00, "open drain value");
    op(1'b1, pc, 8'h00);
    op(1'b1, pd, 8'h00);
    @(posedge clk) #5;
    chk({7'h00, k[1] ? b_oe : a_oe}, 8'h00, "request released");
    lines[k] = !rise;
    op(1'b1, pc, 8'h00);
    @(posedge clk) #5 lines[k] = rise;
    repeat (3) @(posedge clk);
    op(1'b1, pc, 8'h00);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      $display("mismatch at %0t: run did not finish", $time);
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h164082b6));
    rst_b = 1'b0;
    lines = 4'h0;
    pa_in = 8'h00;
    pb_in = 8'h00;
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    zero();
    repeat (12) @(posedge clk);
    #5 rst_b = 1'b1;
    for (int p = 0; p < 4; p++) op(1'b1, 2'(p), 8'h00);
    op(1'b0, hbi_pkg::PICK_CTRL_A, 8'hff);
    op(1'b1, hbi_pkg::PICK_CTRL_A, 8'h00);
    op(1'b0, hbi_pkg::PICK_CTRL_A, 8'h00);
    repeat (60) begin
      @(posedge clk) #5 pa_in = 8'($urandom);
      pb_in = 8'($urandom);
      if ($urandom_range(0, 3) == 0)
        desel(1'($urandom), 2'($urandom), 8'($urandom));
      else
        op(1'($urandom), 2'($urandom), 8'($urandom));
      chk(pa_oe, ddra, "port a direction");
      chk(pb_oe, ddrb, "port b direction");
      chk(pa_out, outa, "port a output");
      chk(pb_out, outb, "port b output");
    end
    // a second reset in mid-run must wipe everything written so far
    @(posedge clk);
    #5 rst_b = 1'b0;
    #10;
    chk({doe, a_oe, b_oe, 5'h00}, 8'h00, "outputs in reset");
    chk(pa_oe | pb_oe, 8'h00, "ports in reset");
    @(posedge clk) #5 rst_b = 1'b1;
    zero();
    for (int p = 0; p < 4; p++) op(1'b1, 2'(p), 8'h00);
    for (int k = 0; k < 4; k++)
      for (int m = 0; m < 4; m++)
        chan(2'(k), m[0], m[1]);
    // two-way lines programmed as outputs must never raise a flag
    for (int k = 1; k < 4; k += 2) begin
      op(1'b0, {k[1], 1'b1}, 8'h3c);
      desel(1'b0, {k[1], 1'b1}, 8'hff);
      @(posedge clk) #5 lines[k] = 1'b0;
      desel(1'b1, {k[1], 1'b0}, 8'h00);
      @(posedge clk) #5 lines[k] = 1'b1;
      repeat (3) @(posedge clk);
      #5 chk({7'h00, k[1] ? b_oe : a_oe}, 8'h00, "output-mode line raised request");
      op(1'b1, {k[1], 1'b1}, 8'h00);
    end
    final_report();
  end
endmodule
`default_nettype wire
